// ===== cpu_reset_mode_checks_asserts.sv
// assertion checker for the reset and mode control block
`timescale 1ns/100ps
`default_nettype none
`include "cpu_reset_mode_map.vh"
module cpu_reset_mode_checks (
  input wire clk_sys, rst, psel, penable, pwrite, mem_rd, core_run, stack_page_select,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [3:0] pstrb,
  input wire [15:0] mem_addr,
  input wire [7:0] processor_flags_word,
  input wire [1:0] oscillator_frequency_select
);
  wire wr = psel && penable && pwrite && pstrb[0] && paddr == `CMC_ADDR;
  wire bad = pwdata[7:6] == `OSC_FORBIDDEN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ord;
    !rst && mem_rd && mem_addr == `VEC_HI_ADDR |=> mem_rd && mem_addr == `VEC_LO_ADDR;
  endproperty
  property p_run; mem_rd && mem_addr == `VEC_LO_ADDR |-> ##[1:4] $rose(core_run); endproperty
  property p_flag; core_run |-> processor_flags_word[`FLAG_BIT_IRQ_DISABLE]; endproperty
  property p_rst; $fell(rst) |-> !stack_page_select && !oscillator_frequency_select; endproperty
  property p_stk; wr |=> stack_page_select == $past(pwdata[`CMC_BIT_STACK]); endproperty
  property p_osc; wr && !bad |=> oscillator_frequency_select == $past(pwdata[7:6]); endproperty
  property p_bad; wr && bad |=> $stable(oscillator_frequency_select); endproperty
  property p_b5; psel && penable && paddr == `CMC_ADDR |-> !prdata[`CMC_BIT_UNUSED]; endproperty
  a_ord: assert property (p_ord) else $error("vector order");
  a_run: assert property (p_run) else $error("core start");
  a_flag: assert property (p_flag) else $error("irq flag");
  a_rst: assert property (p_rst) else $error("mode reset");
  a_stk: assert property (p_stk) else $error("stack bit");
  a_osc: assert property (p_osc) else $error("osc write");
  a_bad: assert property (p_bad) else $error("osc forbidden");
  a_b5: assert property (p_b5) else $error("bit5 read");
  c_run: cover property ($rose(core_run));
  c_wr: cover property (wr);
  c_bad: cover property (wr && bad);
endmodule
bind cpu_reset_mode_control cpu_reset_mode_checks chk_u (.clk_sys, .rst, .psel, .penable,
  .pwrite, .mem_rd, .core_run, .stack_page_select, .paddr, .pwdata, .prdata, .pstrb,
  .mem_addr, .processor_flags_word, .oscillator_frequency_select);
`default_nettype wire

// ===== cpu_reset_mode_control.v
// reset-time core state initialisation and cpu mode control register with apb access
//
// Behaviour
// - on reset release program counter high byte loads from top vector byte
// - program counter low byte loads from the byte just below it
// - after reset interrupt disable flag is 1, other flags undefined
// - processor mode 00 selects single-chip; other codes must not be used, yet a write stores any code in the mode field
// - stack page bit picks page 0 or 1, resets to 0
// - mode bit 5 ignores writes and reads as 0
// - clock switch field: 00 8MHz, 01 12MHz, 10 16MHz, 11 forbidden
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_reset_mode_map.vh"
module cpu_reset_mode_control (
  input wire clk_sys, // system clock, 125 MHz
  input wire rst, // synchronous reset, active high
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb byte strobes
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error
  output wire [15:0] mem_addr, // vector memory address
  output wire mem_rd, // vector memory read strobe
  input wire [7:0] mem_rdata, // vector memory read data
  output reg [7:0] processor_flags_word, // status flags after reset
  output reg [7:0] program_counter_high, // program counter high byte
  output reg [7:0] program_counter_low, // program counter low byte
  output reg core_run, // core may fetch and execute
  output reg [1:0] processor_mode_field, // processor mode
  output reg stack_page_select, // stack page
  output reg [1:0] oscillator_frequency_select // declared main oscillator rate
);
  // ****************************************************************
  // vector fetch
  // ****************************************************************
  wire [15:0] vector;
  wire vec_done;
  vector_fetch u_vec (
    .clk_sys(clk_sys),
    .rst(rst),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_rdata(mem_rdata),
    .vector_ff(vector),
    .done_ff(vec_done)
  );
  always @(posedge clk_sys) begin
    if (rst) begin
      processor_flags_word <= `FLAGS_RESET;
      program_counter_high <= 8'h00;
      program_counter_low <= 8'h00;
      core_run <= 1'b0;
    end else if (vec_done && !core_run) begin
      program_counter_high <= vector[15:8];
      program_counter_low <= vector[7:0];
      core_run <= 1'b1;
    end
  end
  // ****************************************************************
  // mode register
  // ****************************************************************
  wire acc = psel && penable;
  wire wr_cmc = acc && pwrite && pstrb[0] && (paddr == `CMC_ADDR);
  reg [1:0] fixed_ff;
  always @(posedge clk_sys) begin
    if (rst) begin
      processor_mode_field <= `MODE_SINGLE_CHIP;
      stack_page_select <= 1'b0;
      fixed_ff <= 2'h3;
      oscillator_frequency_select <= `OSC_8MHZ;
    end else if (wr_cmc) begin
      processor_mode_field <= pwdata[1:0];
      stack_page_select <= pwdata[`CMC_BIT_STACK];
      fixed_ff <= pwdata[4:3];
      if (pwdata[7:6] != `OSC_FORBIDDEN)
        oscillator_frequency_select <= pwdata[7:6];
    end
  end
  wire [7:0] cmc_rd = {oscillator_frequency_select, 1'b0, fixed_ff, stack_page_select,
                       processor_mode_field};
  // ****************************************************************
  // apb read and answer
  // ****************************************************************
  assign pready = 1'b1;
  assign pslverr = acc && (paddr != `CMC_ADDR) && (paddr != `STAT_ADDR) && (paddr != `PC_ADDR);
  // read word captured in the setup cycle, so it stands through the zero-wait access phase
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        `CMC_ADDR: prdata <= {24'h000000, cmc_rd};
        `STAT_ADDR: prdata <= {23'h000000, core_run, processor_flags_word};
        `PC_ADDR: prdata <= {16'h0000, program_counter_high, program_counter_low};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== cpu_reset_mode_control_test.sv
// self-checking testbench for the reset and mode control block
`timescale 1ns/100ps
`default_nettype none
`include "cpu_reset_mode_map.vh"
module cpu_reset_mode_control_test;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] mem_rdata = 0, vhi, vlo, w;
  logic [1:0] osc;
  logic [64:0] q[$];
  logic [64:0] e;
  int n_fail = 0, compares = 0, cyc = 0;
  wire pready, pslverr, mem_rd, core_run, stack_page_select;
  wire [31:0] prdata;
  wire [15:0] mem_addr;
  wire [7:0] processor_flags_word, program_counter_high, program_counter_low;
  wire [1:0] processor_mode_field, oscillator_frequency_select;
  cpu_reset_mode_control dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .mem_addr, .mem_rd, .mem_rdata,
    .processor_flags_word, .program_counter_high, .program_counter_low, .core_run,
    .processor_mode_field, .stack_page_select, .oscillator_frequency_select);
  initial forever #4 clk_sys = ~clk_sys;
  // vector memory answers a cycle after the strobe, toggles when idle
  always @(posedge clk_sys) mem_rdata <= !mem_rd ? ~mem_rdata : mem_addr[0] ? vhi : vlo;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      complete_run;
    end
  end
  always @(posedge clk_sys) if (psel && penable && pready && !pwrite) begin
    e = q.pop_front();
    compares++;
    if ({pslverr, prdata & e[63:32]} !== {e[64], e[31:0]}) begin
      n_fail++;
      $display("Error %0t read %h", $time, prdata);
    end
    if (paddr == `CMC_ADDR && {oscillator_frequency_select, stack_page_select,
        processor_mode_field} !== {e[7:6], e[2:0]}) begin
      n_fail++;
      $display("Error %0t mode outputs %h", $time, oscillator_frequency_select);
    end
    if (paddr == `PC_ADDR &&
        {program_counter_high, program_counter_low} !== e[15:0]) begin
      n_fail++;
      $display("Error %0t pc outputs %h %h", $time, program_counter_high, program_counter_low);
    end
    if (paddr == `STAT_ADDR && {core_run, processor_flags_word[2]} !== {e[8], e[2]}) begin
      n_fail++;
      $display("Error %0t status outputs %h", $time, processor_flags_word);
    end
  end
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [64:0] x);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) q.push_back(x);
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(80652));
    vhi = 8'($urandom);
    vlo = 8'($urandom);
    osc = `OSC_8MHZ;
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    while (core_run !== 1'b1) @(posedge clk_sys);
    apb(0, `PC_ADDR, 0, {1'b0, 32'hFFFF, 16'h0, vhi, vlo});
    apb(0, `STAT_ADDR, 0, {1'b0, 32'h104, 32'h104});
    apb(0, `CMC_ADDR, 0, {1'b0, 32'hFF, 24'h0, `CMC_RESET});
    apb(0, 12'h100, 0, {1'b1, 64'h0});
    for (int i = 0; i < 4; i++) begin
      w = {i[1:0], 3'h7, 1'($urandom), `MODE_SINGLE_CHIP};
      apb(1, `CMC_ADDR, {24'h0, w}, 0);
      if (i != 3) osc = i[1:0];
      apb(0, `CMC_ADDR, 0, {1'b0, 32'hFF, 24'h0, osc, 3'h3, w[2], 2'h0});
    end
    // a write without its low byte strobe must leave the mode register alone
    pstrb <= 4'h0;
    apb(1, `CMC_ADDR, {24'h0, 2'h0, 3'h7, ~w[2], 2'h0}, 0);
    pstrb <= 4'hF;
    apb(0, `CMC_ADDR, 0, {1'b0, 32'hFF, 24'h0, osc, 3'h3, w[2], 2'h0});
    // second reset in mid-run with a fresh vector
    vhi = 8'($urandom);
    vlo = 8'($urandom);
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    while (core_run !== 1'b1) @(posedge clk_sys);
    apb(0, `PC_ADDR, 0, {1'b0, 32'hFFFF, 16'h0, vhi, vlo});
    apb(0, `CMC_ADDR, 0, {1'b0, 32'hFF, 24'h0, `CMC_RESET});
    complete_run;
  end
endmodule
`default_nettype wire

// ===== cpu_reset_mode_map.vh
// register offsets, field positions, reset values and codes of the reset and mode control block
`ifndef CPU_RESET_MODE_MAP_VH
`define CPU_RESET_MODE_MAP_VH
// ****************************************************************
// register map
// ****************************************************************
`define CMC_INDEX 8'hFB
`define CMC_ADDR 12'h3EC
`define STAT_ADDR 12'h3F0
`define PC_ADDR 12'h3F4
`define VEC_HI_ADDR 16'hFFFF
`define VEC_LO_ADDR 16'hFFFE
// ****************************************************************
// mode register fields
// ****************************************************************
`define CMC_RESET 8'h18
`define CMC_FIXED_ONES 8'h18
`define CMC_BIT_MODE_LO 0
`define CMC_BIT_STACK 2
`define CMC_BIT_UNUSED 5
`define CMC_BIT_OSC_LO 6
`define MODE_SINGLE_CHIP 2'h0
`define OSC_8MHZ 2'h0
`define OSC_12MHZ 2'h1
`define OSC_16MHZ 2'h2
`define OSC_FORBIDDEN 2'h3
`define FLAGS_RESET 8'h04
`define FLAG_BIT_IRQ_DISABLE 2
`endif

// ===== vector_fetch.v
// sequencer that reads the two reset vector bytes from memory
`timescale 1ns/100ps
`default_nettype none
`include "cpu_reset_mode_map.vh"
module vector_fetch (
  input wire clk_sys, // system clock
  input wire rst, // synchronous reset, active high
  output reg [15:0] mem_addr, // memory read address
  output reg mem_rd, // memory read strobe
  input wire [7:0] mem_rdata, // memory read data, one cycle after strobe
  output reg [15:0] vector_ff, // assembled start address
  output reg done_ff // vector loaded
);
  // ****************************************************************
  // state machine
  // ****************************************************************
  localparam ST_HI = 2'h0;
  localparam ST_LO = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_DONE = 2'h3;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  always @* begin
    nxt_state = state_ff;
    mem_rd = 1'b0;
    mem_addr = 16'h0000;
    case (state_ff)
      ST_HI: begin
        mem_rd = 1'b1;
        mem_addr = `VEC_HI_ADDR;
        nxt_state = ST_LO;
      end
      ST_LO: begin
        mem_rd = 1'b1;
        mem_addr = `VEC_LO_ADDR;
        nxt_state = ST_WAIT;
      end
      ST_WAIT: nxt_state = ST_DONE;
      ST_DONE: nxt_state = ST_DONE;
      default: nxt_state = ST_HI;
    endcase
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ST_HI;
      vector_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_LO)
        vector_ff[15:8] <= mem_rdata;
      if (state_ff == ST_WAIT) begin
        vector_ff[7:0] <= mem_rdata;
        done_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
